// ### hw/dcc_pkg.sv
// Package for the dual capture/compare array: map, layouts, types
package dcc_pkg;
	// Data and address widths of the register port
	localparam int DATA_W = 16;
	localparam int ADDR_W = 8;
	localparam int TIMER_W = 16;
	localparam int PRESC_W = 10;
	localparam int CH_PER_UNIT = 16;
	localparam int NUM_CH = 32;
	localparam int NUM_TIMERS = 4;
	// Register map, word addresses
	localparam logic [7:0] ADDR_CH_VALUE = 8'h00;
	localparam logic [7:0] ADDR_CH_CTRL = 8'h20;
	localparam logic [7:0] ADDR_TCTRL0 = 8'h40;
	localparam logic [7:0] ADDR_TCTRL1 = 8'h41;
	localparam logic [7:0] ADDR_TIMER = 8'h44;
	localparam logic [7:0] ADDR_FLAG_LO = 8'h50;
	localparam logic [7:0] ADDR_FLAG_HI = 8'h51;
	localparam logic [7:0] ADDR_EN_LO = 8'h52;
	localparam logic [7:0] ADDR_EN_HI = 8'h53;
	// Timer control field positions: timer a low byte, timer b high byte
	localparam int TB_SHIFT = 8;
	localparam int TCFG_W = 6;
	// Prescaler: full mask is the divide-by-1024 setting
	localparam logic [9:0] PRESC_FULL = 10'h3FF;
	localparam logic [2:0] SEL_MAX = 3'h7;
	// Reset value and counter top
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [15:0] TIMER_TOP = 16'hFFFF;

	// Timer clock source
	typedef enum logic [1:0] {
		DCC_SRC_PRESC = 2'b00,
		DCC_SRC_GP_OVF = 2'b01,
		DCC_SRC_EXT = 2'b10,
		DCC_SRC_OFF = 2'b11
	} dcc_src_type;

	// Channel function
	typedef enum logic [1:0] {
		DCC_FN_OFF = 2'b00,
		DCC_FN_CAPTURE = 2'b01,
		DCC_FN_COMPARE = 2'b10,
		DCC_FN_RSVD = 2'b11
	} dcc_fn_type;

	// Compare modes; double register mode is code 4
	typedef enum logic [2:0] {
		DCC_CMP_IRQ_MULTI = 3'b000,
		DCC_CMP_TOGGLE = 3'b001,
		DCC_CMP_IRQ_ONCE = 3'b010,
		DCC_CMP_SET_CLR = 3'b011,
		DCC_CMP_DOUBLE = 3'b100
	} dcc_cmp_type;

	// Per timer configuration, six bits
	typedef struct packed {
		logic run;
		dcc_src_type src;
		logic [2:0] sel;
	} dcc_tcfg_type;

	// Per channel configuration, low eight bits of the control word
	typedef struct packed {
		dcc_cmp_type cmp;
		logic [1:0] edge_sel;
		logic tsel;
		dcc_fn_type fn;
	} dcc_chcfg_type;

	localparam int CHCFG_W = 8;
endpackage

// ### hw/dcc_array.sv
// Dual capture/compare array: two units, four timers, 32 channels
`timescale 1ns/1ps
`default_nettype none

module dcc_array
	import dcc_pkg::*;
#(
	parameter int UNIT2_OUT_CH = 12
)
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [DATA_W-1:0] rdata_o,
	input wire logic [1:0] ext_count_i,
	input wire logic gp_ovf_i,
	input wire logic [NUM_CH-1:0] pin_i,
	output logic [NUM_CH-1:0] pin_o,
	output logic [NUM_CH-1:0] pin_oe_n_o,
	output logic [NUM_CH-1:0] irq_o
);

	// Elaboration check on the number of unit two outputs
	if (UNIT2_OUT_CH < 0 || UNIT2_OUT_CH > CH_PER_UNIT)
		$error("UNIT2_OUT_CH must lie between 0 and 16");

	// Channels whose pin can be driven at all
	localparam logic [NUM_CH-1:0] OUT_MASK =
		NUM_CH'((64'h1 << (CH_PER_UNIT + UNIT2_OUT_CH)) - 64'h1);

	logic [PRESC_W-1:0] presc;
	logic [1:0] ext_q;
	logic [1:0] ext_edge;
	dcc_tcfg_type tcfg [NUM_TIMERS];
	logic [TIMER_W-1:0] tval [NUM_TIMERS];
	logic [TIMER_W-1:0] treload [NUM_TIMERS];
	logic [NUM_TIMERS-1:0] tupd;
	logic [NUM_TIMERS-1:0] tovf;
	logic [TIMER_W-1:0] ch_value [NUM_CH];
	dcc_chcfg_type ch_cfg [NUM_CH];
	logic [NUM_CH-1:0] ch_match;
	logic [NUM_CH-1:0] ch_event;
	logic [NUM_CH-1:0] flag;
	logic [NUM_CH-1:0] enable;
	logic [DATA_W-1:0] next_rdata;
	logic [ADDR_W-1:0] toff;

	// Free-running prescaler shared by all four timers
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			presc <= '0;
		else if (ce_i)
			presc <= presc + 1'b1;
	end

	// External count inputs arrive synchronous; register for edge detect
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			ext_q <= 2'b00;
		else if (ce_i)
			ext_q <= ext_count_i;
	end

	// identical path per unit
	// Both units see the same latency, so a shared signal keeps them equal
	assign ext_edge = ext_count_i & ~ext_q;

	// Timer control registers, one word per unit
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			for (int t = 0; t < NUM_TIMERS; t++)
				tcfg[t] <= dcc_tcfg_type'(RST_WORD[TCFG_W-1:0]);
		end
		else if (ce_i && wr_i)
		begin
			if (addr_i == ADDR_TCTRL0)
			begin
				tcfg[0] <= dcc_tcfg_type'(wdata_i[TCFG_W-1:0]);
				tcfg[1] <= dcc_tcfg_type'(wdata_i[TB_SHIFT+TCFG_W-1:TB_SHIFT]);
			end
			if (addr_i == ADDR_TCTRL1)
			begin
				tcfg[2] <= dcc_tcfg_type'(wdata_i[TCFG_W-1:0]);
				tcfg[3] <= dcc_tcfg_type'(wdata_i[TB_SHIFT+TCFG_W-1:TB_SHIFT]);
			end
		end
	end

	for (genvar t = 0; t < NUM_TIMERS; t++)
	begin : g_timer
		localparam logic [ADDR_W-1:0] A_CNT = ADDR_W'(ADDR_TIMER + 2 * t);
		localparam logic [ADDR_W-1:0] A_REL = ADDR_W'(ADDR_TIMER + 2 * t + 1);
		logic [PRESC_W-1:0] mask;
		logic tick;

		// divider 8 << sel
		// Tick when the low sel+3 prescaler bits are all ones
		assign mask = PRESC_FULL >> (SEL_MAX - tcfg[t].sel);

		// external count only on the first timer of a unit
		always_comb
		begin
			unique case (tcfg[t].src)
				DCC_SRC_PRESC: tick = (presc & mask) == mask;
				DCC_SRC_GP_OVF: tick = gp_ovf_i;
				DCC_SRC_EXT: tick = (t % 2 == 0) ? ext_edge[t/2] : 1'b0;
				DCC_SRC_OFF: tick = 1'b0;
			endcase
		end

		// Reload register
		always_ff @(posedge clock_i or posedge rst_i)
		begin
			if (rst_i)
				treload[t] <= RST_WORD;
			else if (ce_i && wr_i && addr_i == A_REL)
				treload[t] <= wdata_i;
		end

		// Counter; a software write wins over a tick in the same cycle
		always_ff @(posedge clock_i or posedge rst_i)
		begin
			if (rst_i)
			begin
				tval[t] <= RST_WORD;
				tupd[t] <= 1'b0;
				tovf[t] <= 1'b0;
			end
			else if (ce_i)
			begin
				tupd[t] <= 1'b0;
				tovf[t] <= 1'b0;
				if (wr_i && addr_i == A_CNT)
					tval[t] <= wdata_i;
				else if (tcfg[t].run && tick)
				begin
					tupd[t] <= 1'b1;
					// reload zero runs the full range
					if (tval[t] == TIMER_TOP)
					begin
						tval[t] <= treload[t];
						tovf[t] <= 1'b1;
					end
					else
						tval[t] <= tval[t] + 1'b1;
				end
			end
		end
	end

	for (genvar c = 0; c < NUM_CH; c++)
	begin : g_ch
		localparam int UNIT = c / CH_PER_UNIT;
		localparam int LOCAL = c % CH_PER_UNIT;
		localparam logic [ADDR_W-1:0] A_VAL = ADDR_W'(ADDR_CH_VALUE + c);
		localparam logic [ADDR_W-1:0] A_CFG = ADDR_W'(ADDR_CH_CTRL + c);
		// Double mode pairs channel n with n+8 of the same unit
		localparam int PARTNER = (LOCAL < 8) ? c + 8 : c;
		logic [2:0] pin_sync;
		logic rise;
		logic fall;
		logic cap;
		logic [1:0] tidx;
		logic is_cmp;
		logic once_done;

		assign tidx = {UNIT[0], ch_cfg[c].tsel};
		assign is_cmp = ch_cfg[c].fn == DCC_FN_COMPARE;

		// two-stage synchroniser, edge on later stages
		always_ff @(posedge clock_i or posedge rst_i)
		begin
			if (rst_i)
				pin_sync <= 3'b000;
			else if (ce_i)
				pin_sync <= {pin_sync[1:0], pin_i[c]};
		end

		assign rise = pin_sync[1] & ~pin_sync[2];
		assign fall = ~pin_sync[1] & pin_sync[2];

		assign cap = ch_cfg[c].fn == DCC_FN_CAPTURE &&
			((ch_cfg[c].edge_sel[0] && rise) ||
			(ch_cfg[c].edge_sel[1] && fall));

		// compare on each fresh timer value
		// Comparing only after an update keeps a stopped timer from
		// matching every cycle
		assign ch_match[c] = is_cmp && tupd[tidx] && tval[tidx] == ch_value[c];

		// Configuration register
		always_ff @(posedge clock_i or posedge rst_i)
		begin
			if (rst_i)
				ch_cfg[c] <= dcc_chcfg_type'(RST_WORD[CHCFG_W-1:0]);
			else if (ce_i && wr_i && addr_i == A_CFG)
				ch_cfg[c] <= dcc_chcfg_type'(wdata_i[CHCFG_W-1:0]);
		end

		always_ff @(posedge clock_i or posedge rst_i)
		begin
			if (rst_i)
				ch_value[c] <= RST_WORD;
			else if (ce_i)
			begin
				if (cap)
					ch_value[c] <= tval[tidx];
				else if (wr_i && addr_i == A_VAL)
					ch_value[c] <= wdata_i;
			end
		end

		// one event per period, rearmed by overflow
		always_ff @(posedge clock_i or posedge rst_i)
		begin
			if (rst_i)
				once_done <= 1'b0;
			else if (ce_i)
			begin
				if (tovf[tidx] || !is_cmp)
					once_done <= 1'b0;
				else if (ch_match[c] && (ch_cfg[c].cmp == DCC_CMP_IRQ_ONCE ||
					ch_cfg[c].cmp == DCC_CMP_SET_CLR))
					once_done <= 1'b1;
			end
		end

		always_comb
		begin
			ch_event[c] = cap;
			if (ch_match[c])
			begin
				if (ch_cfg[c].cmp == DCC_CMP_IRQ_ONCE ||
					ch_cfg[c].cmp == DCC_CMP_SET_CLR)
					ch_event[c] = !once_done;
				else
					ch_event[c] = 1'b1;
			end
		end

		// pin drive and direction per channel
		// channels without an output never drive
		always_ff @(posedge clock_i or posedge rst_i)
		begin
			if (rst_i)
			begin
				pin_o[c] <= 1'b0;
				pin_oe_n_o[c] <= 1'b1;
			end
			else if (ce_i)
			begin
				pin_oe_n_o[c] <= !(OUT_MASK[c] && is_cmp &&
					ch_cfg[c].cmp != DCC_CMP_IRQ_MULTI &&
					ch_cfg[c].cmp != DCC_CMP_IRQ_ONCE);
				if (!OUT_MASK[c])
					pin_o[c] <= 1'b0;
				else if (is_cmp && ch_cfg[c].cmp == DCC_CMP_TOGGLE &&
					ch_match[c])
					pin_o[c] <= !pin_o[c];
				// either register of the pair toggles
				else if (is_cmp && ch_cfg[c].cmp == DCC_CMP_DOUBLE &&
					(ch_match[c] || (PARTNER != c && ch_match[PARTNER])))
					pin_o[c] <= !pin_o[c];
				// set on match, clear on overflow
				else if (is_cmp && ch_cfg[c].cmp == DCC_CMP_SET_CLR)
				begin
					if (tovf[tidx])
						pin_o[c] <= 1'b0;
					else if (ch_match[c] && !once_done)
						pin_o[c] <= 1'b1;
				end
			end
		end
	end

	// request flags; a hardware set beats a software clear
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			flag <= '0;
		else if (ce_i)
		begin
			if (wr_i && addr_i == ADDR_FLAG_LO)
				flag <= {flag[31:16], wdata_i} | ch_event;
			else if (wr_i && addr_i == ADDR_FLAG_HI)
				flag <= {wdata_i, flag[15:0]} | ch_event;
			else
				flag <= flag | ch_event;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			enable <= '0;
		else if (ce_i && wr_i)
		begin
			if (addr_i == ADDR_EN_LO)
				enable[15:0] <= wdata_i;
			if (addr_i == ADDR_EN_HI)
				enable[31:16] <= wdata_i;
		end
	end

	// Gated requests leave as registered levels, one per channel
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			irq_o <= '0;
		else if (ce_i)
			irq_o <= flag & enable;
	end

	// Timer words start at an unaligned base, so index from the offset
	assign toff = addr_i - ADDR_TIMER;

	// Read decode; unmapped addresses read zero
	always_comb
	begin
		next_rdata = RST_WORD;
		if (addr_i < ADDR_CH_CTRL)
			next_rdata = ch_value[addr_i[4:0]];
		else if (addr_i < ADDR_TCTRL0)
			next_rdata = {8'h00, ch_cfg[addr_i[4:0]]};
		else if (addr_i == ADDR_TCTRL0)
			next_rdata = {2'b00, tcfg[1], 2'b00, tcfg[0]};
		else if (addr_i == ADDR_TCTRL1)
			next_rdata = {2'b00, tcfg[3], 2'b00, tcfg[2]};
		else if (addr_i >= ADDR_TIMER && addr_i < ADDR_TIMER + 8'h08)
			next_rdata = toff[0] ? treload[toff[2:1]] : tval[toff[2:1]];
		else if (addr_i == ADDR_FLAG_LO)
			next_rdata = flag[15:0];
		else if (addr_i == ADDR_FLAG_HI)
			next_rdata = flag[31:16];
		else if (addr_i == ADDR_EN_LO)
			next_rdata = enable[15:0];
		else if (addr_i == ADDR_EN_HI)
			next_rdata = enable[31:16];
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			rdata_o <= RST_WORD;
		else if (ce_i)
			rdata_o <= rd_i ? next_rdata : RST_WORD;
	end

endmodule // dcc_array

`default_nettype wire

// ### tb/dcc_sva.sv
// Port checker for the capture/compare array
`timescale 1ns/1ps
`default_nettype none
module dcc_sva
	import dcc_pkg::*;
#(
	parameter int UNIT2_OUT_CH = 12
)
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [DATA_W-1:0] rdata_o,
	input wire logic [NUM_CH-1:0] pin_o,
	input wire logic [NUM_CH-1:0] pin_oe_n_o,
	input wire logic [NUM_CH-1:0] irq_o
);
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);

	// Read data stands one cycle only
	AST_RDATA_IDLE: assert property (ce_i && !rd_i |=> rdata_o == RST_WORD)
		else $error("read data outside answer cycle");
	// Clock enable low freezes every output
	AST_FREEZE_PIN: assert property (!ce_i |=> $stable(pin_o))
		else $error("pin moved while frozen");
	AST_FREEZE_IRQ: assert property (!ce_i |=> irq_o == $past(irq_o))
		else $error("request moved while frozen");
	AST_FREEZE_RD: assert property (!ce_i ##1 !ce_i |-> $stable(rdata_o))
		else $error("read data moved while frozen");
	AST_FREEZE_OE: assert property (!ce_i |=> $stable(pin_oe_n_o))
		else $error("enable moved while frozen");
	// Input-only channels never drive, whatever the setup
	AST_INONLY_OE: assert property
		(&pin_oe_n_o[NUM_CH-1:CH_PER_UNIT+UNIT2_OUT_CH])
		else $error("input-only channel drives");
	// A request drops only two edges after a write
	AST_IRQ_FALL_WR: assert property
		(|($past(irq_o) & ~irq_o) |-> $past(wr_i, 2))
		else $error("request fell without a write");
	// Pin direction follows channel setup writes only
	AST_OE_CHG_WR: assert property
		($changed(pin_oe_n_o) |-> $past(wr_i) || $past(wr_i, 2))
		else $error("pin direction changed without a write");
endmodule // dcc_sva

bind dcc_array dcc_sva #(.UNIT2_OUT_CH(UNIT2_OUT_CH)) u_sva (
	.clock_i(clock_i),
	.rst_i(rst_i),
	.ce_i(ce_i),
	.wr_i(wr_i),
	.rd_i(rd_i),
	.rdata_o(rdata_o),
	.pin_o(pin_o),
	.pin_oe_n_o(pin_oe_n_o),
	.irq_o(irq_o)
);
`default_nettype wire

// ### tb/dcc_far.sv
// Far-side model: external count input and capture pins
`timescale 1ns/1ps
`default_nettype none
module dcc_far
	import dcc_pkg::*;
(
	input wire logic clock_i,
	output logic [1:0] ext_count_o,
	output logic gp_ovf_o,
	output logic [NUM_CH-1:0] pin_o
);
	// Quiet lines until a scenario asks for events
	initial
	begin
		ext_count_o = 2'h0;
		gp_ovf_o = 1'b0;
		pin_o = '0;
	end
	task automatic count(input int n);
		repeat (n)
		begin
			@(posedge clock_i);
			ext_count_o <= 2'h3;
			repeat (4) @(posedge clock_i);
			ext_count_o <= 2'h0;
			repeat (4) @(posedge clock_i);
		end
	endtask
	// one-cycle overflow pulses from the general timer
	task automatic ovf(input int n);
		repeat (n)
		begin
			@(posedge clock_i);
			gp_ovf_o <= 1'b1;
			@(posedge clock_i);
			gp_ovf_o <= 1'b0;
		end
	endtask
	// one edge, then time to settle
	task automatic drive(input int ch, input logic lvl);
		@(posedge clock_i);
		pin_o[ch] <= lvl;
		repeat (6) @(posedge clock_i);
	endtask
endmodule // dcc_far
`default_nettype wire

// ### tb/tb_dual_capture_compare_array.sv
// Self-checking bench for the capture/compare array
`timescale 1ns/1ps
`default_nettype none
module tb_dual_capture_compare_array
	import dcc_pkg::*;
;
	logic clock_i, rst_i, ce_i, wr_i, rd_i, rd_seen, gp_ovf_i;
	logic [ADDR_W-1:0] addr_i;
	logic [DATA_W-1:0] wdata_i, rdata_o;
	logic [1:0] ext_count_i;
	logic [NUM_CH-1:0] pin_i, pin_o, pin_oe_n_o, irq_o;
	logic [DATA_W-1:0] exp_q[$];
	int err_total, n_checks, seed, n;

	dcc_array u_dut (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .ext_count_i(ext_count_i),
		.gp_ovf_i(gp_ovf_i), .pin_i(pin_i), .pin_o(pin_o),
		.pin_oe_n_o(pin_oe_n_o), .irq_o(irq_o));
	dcc_far u_far (.clock_i(clock_i), .ext_count_o(ext_count_i),
		.gp_ovf_o(gp_ovf_i), .pin_o(pin_i));

	// Free-running clock
	initial
	begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		n_checks++;
		if (seen !== want)
		begin
			err_total++;
			$display("ERROR %0t got %h want %h", $time, seen, want);
		end
	endtask

	task automatic summarize();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clock_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask

	// Expected read value goes on the queue first
	task automatic rd(input logic [7:0] a, input logic [15:0] d);
		exp_q.push_back(d);
		@(posedge clock_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clock_i);
		rd_i <= 1'b0;
	endtask

	// Answer lives only in the cycle after the strobe
	always @(posedge clock_i) rd_seen <= rd_i & ce_i;
	always @(negedge clock_i)
		if (rd_seen === 1'b1)
			check(rdata_o, exp_q.pop_front());

	// Main sequence
	initial
	begin
		err_total = 0;
		n_checks = 0;
		seed = 45124;
		n = 3 + ($random(seed) & 7);
		rst_i = 1'b1;
		ce_i = 1'b1;
		wr_i = 1'b0;
		rd_i = 1'b0;
		addr_i = '0;
		wdata_i = '0;
		repeat (16) @(posedge clock_i);
		rst_i <= 1'b0;
		check(pin_oe_n_o[31:16], 16'hFFFF);
		check(irq_o[15:0], 16'h0000);
		wr(ADDR_TCTRL0, 16'h0030);
		wr(ADDR_TCTRL1, 16'h0030);
		wr(ADDR_CH_CTRL, 16'h0009);
		wr(ADDR_EN_LO, 16'hFFFF);
		u_far.count(n);
		rd(ADDR_TIMER, 16'(n));
		rd(ADDR_TIMER + 8'h04, 16'(n));
		u_far.drive(0, 1'b1);
		rd(ADDR_CH_VALUE, 16'(n));
		check(irq_o[15:0], 16'h0001);
		// Falling edge is not selected, so no second capture
		u_far.count(1);
		u_far.drive(0, 1'b0);
		rd(ADDR_CH_VALUE, 16'(n));
		// Channel 1 toggles, channels 2 to 6 take modes 0 to 4
		for (int m = 0; m < 6; m++)
		begin
			wr(ADDR_CH_VALUE + 8'(m + 1), 16'(n + 3));
			wr(ADDR_CH_CTRL + 8'(m + 1), 16'((m == 0 ? 1 : m - 1) * 32 + 2));
		end
		repeat (3) @(posedge clock_i);
		check(pin_oe_n_o[15:0], 16'hFF95);
		u_far.count(2);
		check(pin_o[15:0], 16'h006A);
		rd(ADDR_FLAG_LO, 16'h007F);
		// Overflow reloads and clears the set-on-match pin
		wr(ADDR_TIMER + 8'h01, 16'h0005);
		wr(ADDR_TIMER, 16'hFFFF);
		u_far.count(1);
		rd(ADDR_TIMER, 16'h0005);
		check(pin_o[15:0], 16'h004A);
		// Timer b of unit one counts overflow pulses; both edges capture
		wr(ADDR_TCTRL0, 16'h2830);
		u_far.ovf(3);
		rd(ADDR_TIMER + 8'h02, 16'h0003);
		wr(ADDR_CH_CTRL + 8'h07, 16'h001D);
		u_far.drive(7, 1'b1);
		rd(ADDR_CH_VALUE + 8'h07, 16'h0003);
		u_far.ovf(1);
		u_far.drive(7, 1'b0);
		rd(ADDR_CH_VALUE + 8'h07, 16'h0004);
		// Prescaled timer b of unit two: channel 16 toggles, 28 never drives
		wr(ADDR_CH_VALUE + 8'h10, 16'h0004);
		wr(ADDR_CH_VALUE + 8'h1C, 16'h0004);
		wr(ADDR_CH_CTRL + 8'h10, 16'h0026);
		wr(ADDR_CH_CTRL + 8'h1C, 16'h0026);
		repeat (3) @(posedge clock_i);
		check(pin_oe_n_o[31:16], 16'hFFFE);
		// Divide by 8 reaches the fourth tick well inside 40 cycles
		wr(ADDR_TCTRL1, 16'h2030);
		repeat (40) @(posedge clock_i);
		check(pin_o[31:16], 16'h0001);
		wr(ADDR_FLAG_LO, 16'h0000);
		repeat (3) @(posedge clock_i);
		check(irq_o[15:0], 16'h0000);
		rd(8'hFF, 16'h0000);
		// Frozen span: counts and writes are ignored, outputs hold
		ce_i <= 1'b0;
		u_far.count(1);
		wr(ADDR_FLAG_LO, 16'h00FF);
		ce_i <= 1'b1;
		repeat (4) @(posedge clock_i);
		check(irq_o[15:0], 16'h0000);
		rd(ADDR_TIMER, 16'h0005);
		// Let the last answer be compared before the verdict
		repeat (2) @(posedge clock_i);
		summarize();
	end

	// Hang guard
	initial
	begin
		#100000;
		err_total++;
		summarize();
	end
endmodule // tb_dual_capture_compare_array
`default_nettype wire
